// File: hw/dpio_pkg.sv
// package: register map, field positions, reset values and carrier types for the dual port io
package dpio_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_WIDE_PINS = 4'h0;
   localparam logic [3:0] ADDR_WIDE_LATCH = 4'h1;
   localparam logic [3:0] ADDR_WIDE_DIRECTION = 4'h2;
   localparam logic [3:0] ADDR_NARROW_PINS = 4'h3;
   localparam logic [3:0] ADDR_NARROW_LATCH = 4'h4;
   localparam logic [3:0] ADDR_NARROW_DIRECTION = 4'h5;
   localparam logic [3:0] ADDR_ANALOG_PIN_CONFIG = 4'h6;
   localparam logic [3:0] ADDR_DEVICE_CONFIG = 4'h7;

   // ----------------------------------------------------------------
   // widths and field positions
   // ----------------------------------------------------------------
   localparam int WIDE_W = 8;
   localparam int NARROW_W = 3;
   localparam int DIR_INPUT_FULL = 7;
   localparam int DIR_OUTPUT_FULL = 6;
   localparam int DIR_INPUT_OVERFLOW = 5;
   localparam int DIR_SLAVE_ENABLE = 4;
   localparam int CFG_CAPTURE2_SELECT = 0;
   localparam int WIDE_CAPTURE2_BIT = 1;
   localparam int STROBE_READ_BIT = 0;
   localparam int STROBE_WRITE_BIT = 1;
   localparam int STROBE_SELECT_BIT = 2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] WIDE_DIR_RESET = 8'hff;
   localparam logic [7:0] WIDE_LATCH_RESET = 8'h00;
   localparam logic [2:0] NARROW_DIR_RESET = 3'h7;
   localparam logic [2:0] NARROW_LATCH_RESET = 3'h0;
   localparam logic [3:0] SLAVE_CTRL_RESET = 4'h0;
   localparam logic [7:0] ANALOG_CFG_RESET = 8'h00;
   localparam logic [7:0] ANALOG_MASK = 8'h3f;
   // analog select field values below this threshold keep channels five to seven analog
   localparam logic [3:0] ANALOG_DIGITAL_THRESHOLD = 4'ha;
   localparam logic CAPTURE2_SELECT_RESET = 1'b1;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dpio_bus_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
   } dpio_wide_drive_t;

   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe_n;
   } dpio_narrow_drive_t;

   typedef struct packed {
      logic [7:0] force_en;
      logic [7:0] force_out;
   } dpio_override_t;

endpackage : dpio_pkg

// File: hw/dpio_top.sv
// design: wide and narrow general-purpose io ports with slave port strobe pins
`timescale 1ns/100ps
// ----------------------------------------------------------------
// operating notes
// ----------------------------------------------------------------
// register port:
//    a write strobe is taken at the rising edge where it is high and the
//    new value is visible on the drivers from the next cycle on.
//    a read strobe is taken the same way; read data stand for exactly one
//    cycle after the strobe and fall back to zero, so an idle bus reads 0.
//    back to back strobes are legal; the slave never inserts wait states.
//    unmapped addresses read zero and swallow writes.
//
// wide port:
//    the direction register is software owned; a peripheral override only
//    changes the effective enable on the pin, never the stored bits, so a
//    read of the direction register always shows what was last written.
//    writes to the pin register land in the latch; this keeps
//    read-modify-write on the latch free of pin-level surprises.
//    capture unit two drives bit one only while its select bit is set and
//    the override forces that pin; it reads bit one whenever the select is set.
//
// narrow port:
//    the three low pins start as analog inputs; the digital read path is
//    masked to zero while analog, but the direction bits still rule the
//    drivers, so software must keep analog pins as inputs.
//    the upper direction bits carry the slave port flags and its enable.
//    flag clear and hardware set may meet in one cycle; the set wins so
//    that no buffer event is ever lost.
//
// limitations:
//    pin reads lag the pins by two clocks of synchroniser latency plus the
//    one cycle of registered read data.
//    the strobe pins are passed on synchronised but not edge detected;
//    the slave port logic itself decides what a strobe means.
//    the synchronisers carry no reset: their contents are overwritten by
//    the pins within two clocks; during reset only capture2_in passes bit one of them on.
//
// trade-offs:
//    drive outputs are combinational from registers, which keeps the
//    override path free of a cycle of delay at the cost of a short
//    combinational path to the pads.
//    read data are registered so the register port timing does not depend
//    on the depth of the read mux.
module dpio_top (
   input wire logic clk,
   input wire logic rst_n,
   input dpio_pkg::dpio_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] wide_pin_in,
   output dpio_pkg::dpio_wide_drive_t wide_drive,
   input wire logic [2:0] narrow_pin_in,
   output dpio_pkg::dpio_narrow_drive_t narrow_drive,
   input dpio_pkg::dpio_override_t wide_override,
   input wire logic capture2_out,
   output logic capture2_in,
   input wire logic [2:0] slave_flags_set,
   input wire logic slave_flags_clear,
   output logic slave_port_enable,
   output logic [2:0] slave_strobes,
   output logic [2:0] analog_channel_en
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] wide_port_latch;
   logic [7:0] wide_port_direction;
   logic [2:0] narrow_port_latch;
   logic [2:0] narrow_dir;
   logic [3:0] slave_ctrl;
   logic [7:0] analog_pin_config;
   logic capture2_pin_select;
   logic [7:0] wide_sync1;
   logic [7:0] wide_sync2;
   logic [2:0] narrow_sync1;
   logic [2:0] narrow_sync2;
   logic [7:0] next_rdata;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic hit(input dpio_pkg::dpio_bus_req_t r, input logic [3:0] a);
      hit = r.wr && (r.addr == a);
   endfunction : hit

   wire wr_wide_latch = hit(bus_req, dpio_pkg::ADDR_WIDE_LATCH)
                        || hit(bus_req, dpio_pkg::ADDR_WIDE_PINS);
   wire wr_wide_dir = hit(bus_req, dpio_pkg::ADDR_WIDE_DIRECTION);
   wire wr_narrow_latch = hit(bus_req, dpio_pkg::ADDR_NARROW_LATCH)
                          || hit(bus_req, dpio_pkg::ADDR_NARROW_PINS);
   wire wr_narrow_dir = hit(bus_req, dpio_pkg::ADDR_NARROW_DIRECTION);
   wire wr_analog = hit(bus_req, dpio_pkg::ADDR_ANALOG_PIN_CONFIG);
   wire wr_cfg = hit(bus_req, dpio_pkg::ADDR_DEVICE_CONFIG);

   // analog select field below threshold keeps all three narrow pins analog
   wire [3:0] analog_select_field = analog_pin_config[3:0];
   wire narrow_analog = analog_select_field < dpio_pkg::ANALOG_DIGITAL_THRESHOLD;

   // ----------------------------------------------------------------
   // pin synchronisers: pins are asynchronous to clk
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      wide_sync1 <= wide_pin_in;
      wide_sync2 <= wide_sync1;
      narrow_sync1 <= narrow_pin_in;
      narrow_sync2 <= narrow_sync1;
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wide_port_latch <= dpio_pkg::WIDE_LATCH_RESET;
         wide_port_direction <= dpio_pkg::WIDE_DIR_RESET;
         narrow_port_latch <= dpio_pkg::NARROW_LATCH_RESET;
         narrow_dir <= dpio_pkg::NARROW_DIR_RESET;
         analog_pin_config <= dpio_pkg::ANALOG_CFG_RESET;
         capture2_pin_select <= dpio_pkg::CAPTURE2_SELECT_RESET;
      end else begin
         if (wr_wide_latch) begin
            wide_port_latch <= bus_req.wdata;
         end
         if (wr_wide_dir) begin
            wide_port_direction <= bus_req.wdata;
         end
         if (wr_narrow_latch) begin
            narrow_port_latch <= bus_req.wdata[2:0];
         end
         if (wr_narrow_dir) begin
            narrow_dir <= bus_req.wdata[2:0];
         end
         if (wr_analog) begin
            analog_pin_config <= bus_req.wdata & dpio_pkg::ANALOG_MASK;
         end
         if (wr_cfg) begin
            capture2_pin_select <= bus_req.wdata[dpio_pkg::CFG_CAPTURE2_SELECT];
         end
      end
   end

   // slave port flags: hardware sets win over software clears; enable is software owned
   wire [2:0] flags_now = slave_ctrl[3:1];
   wire [2:0] next_flags = (wr_narrow_dir ? bus_req.wdata[7:5] & flags_now : flags_now)
                           & ~{3{slave_flags_clear}} | slave_flags_set;
   wire next_enable = wr_narrow_dir ? bus_req.wdata[dpio_pkg::DIR_SLAVE_ENABLE] : slave_ctrl[0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         slave_ctrl <= dpio_pkg::SLAVE_CTRL_RESET;
      end else begin
         slave_ctrl <= {next_flags, next_enable};
      end
   end

   // ----------------------------------------------------------------
   // wide port drivers: override wins over direction bit
   // ----------------------------------------------------------------
   logic [7:0] wide_eff_dir;
   logic [7:0] wide_eff_out;
   always_comb begin
      wide_eff_dir = wide_port_direction;
      wide_eff_out = wide_port_latch;
      for (int i = 0; i < dpio_pkg::WIDE_W; i++) begin
         if (wide_override.force_en[i]) begin
            wide_eff_dir[i] = ~wide_override.force_out[i];
         end
      end
      // capture unit two drives bit one when routed here and the override enable of that pin is set, whatever its forced direction
      if (capture2_pin_select && wide_override.force_en[dpio_pkg::WIDE_CAPTURE2_BIT]) begin
         wide_eff_out[dpio_pkg::WIDE_CAPTURE2_BIT] = capture2_out;
      end
   end

   // a one in the effective direction floats the driver; oe_n low means driving
   assign wide_drive.out = wide_eff_out;
   assign wide_drive.oe_n = wide_eff_dir;
   assign capture2_in = capture2_pin_select & wide_sync2[dpio_pkg::WIDE_CAPTURE2_BIT];

   // ----------------------------------------------------------------
   // narrow port drivers and strobe inputs
   // ----------------------------------------------------------------
   // direction still rules the driver in analog mode, so output drive ignores analog
   assign narrow_drive.out = narrow_port_latch;
   assign narrow_drive.oe_n = narrow_dir;
   wire [2:0] narrow_digital = narrow_analog ? 3'h0 : narrow_sync2;
   assign slave_port_enable = slave_ctrl[0];
   assign slave_strobes = (slave_ctrl[0] && !narrow_analog) ? (narrow_sync2 & narrow_dir)
                                                            : 3'h0;
   assign analog_channel_en = narrow_analog ? 3'h7 : 3'h0;

   // ----------------------------------------------------------------
   // read mux, data one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      case (bus_req.addr)
         dpio_pkg::ADDR_WIDE_PINS: next_rdata = wide_sync2;
         dpio_pkg::ADDR_WIDE_LATCH: next_rdata = wide_port_latch;
         dpio_pkg::ADDR_WIDE_DIRECTION: next_rdata = wide_port_direction;
         dpio_pkg::ADDR_NARROW_PINS: next_rdata = {5'h00, narrow_digital};
         dpio_pkg::ADDR_NARROW_LATCH: next_rdata = {5'h00, narrow_port_latch};
         dpio_pkg::ADDR_NARROW_DIRECTION: next_rdata = {slave_ctrl, 1'b0, narrow_dir};
         dpio_pkg::ADDR_ANALOG_PIN_CONFIG: next_rdata = analog_pin_config;
         dpio_pkg::ADDR_DEVICE_CONFIG: next_rdata = {7'h00, capture2_pin_select};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= bus_req.rd ? next_rdata : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_WIDE_DIR_RESET: assert property (@(posedge clk) !rst_n |=> wide_drive.oe_n == 8'hff)
      else $error("wide pins not inputs after reset");
   AST_NARROW_ANALOG_RESET: assert property (@(posedge clk) !rst_n |=> analog_channel_en == 3'h7)
      else $error("narrow pins not analog after reset");
   AST_WIDE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
      (wide_override.force_en == 8'h00 && capture2_out == 1'b0)
      |-> wide_drive.oe_n == wide_port_direction)
      else $error("wide driver not following direction");
   AST_LATCH_READ: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req.rd && bus_req.addr == dpio_pkg::ADDR_WIDE_LATCH
      |=> bus_rdata == $past(wide_port_latch))
      else $error("latch read mismatch");
   // write then immediate read of the direction register returns the write
   sequence seq_dir_write;
      wr_wide_dir;
   endsequence
   sequence seq_dir_read;
      bus_req.rd && bus_req.addr == dpio_pkg::ADDR_WIDE_DIRECTION;
   endsequence
   AST_DIR_WRITE_READ: assert property (@(posedge clk) disable iff (!rst_n)
      seq_dir_write ##1 seq_dir_read
      |=> bus_rdata == $past(bus_req.wdata, 2))
      else $error("direction readback differs from write");
   AST_ANALOG_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req.rd && bus_req.addr == dpio_pkg::ADDR_NARROW_PINS && narrow_analog
      |=> bus_rdata == 8'h00)
      else $error("analog pin read not zero");
   AST_NARROW_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req.rd && bus_req.addr == dpio_pkg::ADDR_NARROW_LATCH
      |=> bus_rdata[7:3] == 5'h00)
      else $error("unimplemented bits not zero");
   AST_NARROW_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_narrow_latch |=> narrow_drive.out == $past(bus_req.wdata[2:0]))
      else $error("narrow latch not driven");
   AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
      slave_flags_set[0] && slave_flags_clear |=> slave_ctrl[1])
      else $error("flag set lost on clear");

   // ----------------------------------------------------------------
   // further checks on drivers, strobes and the read path
   // ----------------------------------------------------------------
   // with no override the wide pins carry the latch unchanged
   AST_WIDE_OUT_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      wide_override.force_en == 8'h00 |-> wide_drive.out == wide_port_latch)
      else $error("wide output not from latch");
   // a forced pin follows the override, not the direction bit
   AST_OVERRIDE_DIR: assert property (@(posedge clk) disable iff (!rst_n)
      wide_override.force_en[0] |-> wide_drive.oe_n[0] == !wide_override.force_out[0])
      else $error("override not applied to wide pin");
   // capture unit two owns bit one only while routed and the override enable of bit one is set
   AST_CAPTURE2_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
      capture2_pin_select && wide_override.force_en[dpio_pkg::WIDE_CAPTURE2_BIT]
      |-> wide_drive.out[dpio_pkg::WIDE_CAPTURE2_BIT] == capture2_out)
      else $error("capture unit output not on wide bit one");
   // narrow enables follow the stored direction even in analog mode
   AST_NARROW_OE: assert property (@(posedge clk) disable iff (!rst_n)
      narrow_drive.oe_n == narrow_dir)
      else $error("narrow enable differs from direction");
   // strobes are silent while the slave port is disabled
   AST_STROBE_GATED: assert property (@(posedge clk) disable iff (!rst_n)
      !slave_ctrl[0] |-> slave_strobes == 3'h0)
      else $error("strobe passed while slave port disabled");
   // read data fall back to zero when no read was taken
   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      !bus_req.rd |=> bus_rdata == 8'h00)
      else $error("read data standing without a read");
   // the pin register reads the synchronised levels
   AST_PIN_READ_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req.rd && bus_req.addr == dpio_pkg::ADDR_WIDE_PINS
      |=> bus_rdata == $past(wide_sync2))
      else $error("wide pin read not synchronised level");
   // the gap bit of the narrow direction register always reads zero
   AST_NARROW_DIR_GAP: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req.rd && bus_req.addr == dpio_pkg::ADDR_NARROW_DIRECTION
      |=> bus_rdata[3] == 1'b0)
      else $error("unimplemented direction bit not zero");

   // a clear with no set empties all three flags; the enable is untouched
   sequence seq_clear_alone;
      slave_flags_clear && slave_flags_set == 3'h0 && !wr_narrow_dir;
   endsequence
   sequence seq_flags_empty;
      slave_ctrl[3:1] == 3'h0;
   endsequence
   AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      seq_clear_alone |=> seq_flags_empty)
      else $error("flags not cleared");

endmodule : dpio_top

// File: test/dpio_board.sv
// board model: resolves every port pin from the device driver and the board's own level
`timescale 1ns/100ps
module dpio_board (
   input wire logic [7:0] wide_level,
   input wire logic [2:0] narrow_level,
   input dpio_pkg::dpio_wide_drive_t wide_drive,
   input dpio_pkg::dpio_narrow_drive_t narrow_drive,
   output logic [7:0] wide_pin,
   output logic [2:0] narrow_pin
);
   // ----------------------------------------------------------------
   // pin resolution
   // ----------------------------------------------------------------
   // a floating driver leaves the board level on the wire, never a stale device value
   assign wide_pin = (wide_drive.out & ~wide_drive.oe_n) | (wide_level & wide_drive.oe_n);
   assign narrow_pin = (narrow_drive.out & ~narrow_drive.oe_n)
      | (narrow_level & narrow_drive.oe_n);
endmodule : dpio_board

// File: test/testbench.sv
// testbench: register port scenarios for both ports against the board model
`timescale 1ns/100ps
module testbench;
   logic clk, rst_n, capture2_out, capture2_in, slave_flags_clear, slave_port_enable;
   dpio_pkg::dpio_bus_req_t bus_req;
   dpio_pkg::dpio_wide_drive_t wide_drive;
   dpio_pkg::dpio_narrow_drive_t narrow_drive;
   dpio_pkg::dpio_override_t wide_override;
   logic [7:0] bus_rdata, wide_pin_in, board_wide, rd_val;
   logic [2:0] narrow_pin_in, board_narrow, slave_flags_set, slave_strobes, analog_channel_en;
   int n_mismatch, samples_checked;

   dpio_top u_dpio_top (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .wide_pin_in(wide_pin_in), .wide_drive(wide_drive), .narrow_pin_in(narrow_pin_in),
      .narrow_drive(narrow_drive), .wide_override(wide_override), .capture2_out(capture2_out),
      .capture2_in(capture2_in), .slave_flags_set(slave_flags_set),
      .slave_flags_clear(slave_flags_clear), .slave_port_enable(slave_port_enable),
      .slave_strobes(slave_strobes), .analog_channel_en(analog_channel_en));
   dpio_board u_dpio_board (.wide_level(board_wide), .narrow_level(board_narrow),
      .wide_drive(wide_drive), .narrow_drive(narrow_drive), .wide_pin(wide_pin_in),
      .narrow_pin(narrow_pin_in));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // edge counting only, then step off the edge so sampling never races the design
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      rd_val = bus_rdata;
   endtask : rd
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk(wide_drive.oe_n, 8'hff);
      chk({2'h0, narrow_drive.oe_n, analog_channel_en}, 8'h3f);
      rd(dpio_pkg::ADDR_WIDE_DIRECTION);
      chk(rd_val, 8'hff);
      rd(dpio_pkg::ADDR_NARROW_DIRECTION);
      chk(rd_val, 8'h07);
      rd(dpio_pkg::ADDR_DEVICE_CONFIG);
      chk(rd_val & 8'h01, 8'h01);
      rd(dpio_pkg::ADDR_NARROW_PINS);
      chk(rd_val, 8'h00);
   endtask : t_reset
   task automatic t_wide;
      wr(dpio_pkg::ADDR_WIDE_LATCH, 8'ha5);
      wr(dpio_pkg::ADDR_WIDE_DIRECTION, 8'h0f);
      chk(wide_drive.oe_n, 8'h0f);
      chk(wide_drive.out, 8'ha5);
      rd(dpio_pkg::ADDR_WIDE_LATCH);
      chk(rd_val, 8'ha5);
      // write then read with no gap between the strobes
      @(posedge clk);
      bus_req <= '{addr: dpio_pkg::ADDR_WIDE_DIRECTION, wdata: 8'h0f, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req <= '{addr: dpio_pkg::ADDR_WIDE_DIRECTION, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      chk(bus_rdata, 8'h0f);
      tick(3);
      rd(dpio_pkg::ADDR_WIDE_PINS);
      chk(rd_val, 8'hac);
      wr(dpio_pkg::ADDR_WIDE_PINS, 8'h5a);
      rd(dpio_pkg::ADDR_WIDE_LATCH);
      chk(rd_val, 8'h5a);
   endtask : t_wide
   task automatic t_override;
      @(posedge clk);
      wide_override <= '{force_en: 8'h03, force_out: 8'h01};
      tick(1);
      chk(wide_drive.oe_n, 8'h0e);
      rd(dpio_pkg::ADDR_WIDE_DIRECTION);
      chk(rd_val, 8'h0f);
      @(posedge clk);
      wide_override <= '{force_en: 8'h02, force_out: 8'h02};
      tick(1);
      chk(wide_drive.out, 8'h58);
      @(posedge clk);
      wide_override <= '{force_en: 8'h00, force_out: 8'h00};
      board_wide <= 8'h3e;
      tick(3);
      chk({7'h00, capture2_in}, 8'h01);
      wr(dpio_pkg::ADDR_DEVICE_CONFIG, 8'h00);
      rd(dpio_pkg::ADDR_DEVICE_CONFIG);
      chk(rd_val, 8'h00);
      chk({7'h00, capture2_in}, 8'h00);
   endtask : t_override
   task automatic t_narrow;
      wr(dpio_pkg::ADDR_NARROW_LATCH, 8'hff);
      rd(dpio_pkg::ADDR_NARROW_LATCH);
      chk(rd_val, 8'h07);
      wr(dpio_pkg::ADDR_NARROW_LATCH, 8'h02);
      // pins go digital before any driver opens, keeping analog pins as inputs
      wr(dpio_pkg::ADDR_ANALOG_PIN_CONFIG, 8'h0a);
      chk({5'h00, analog_channel_en}, 8'h00);
      wr(dpio_pkg::ADDR_NARROW_DIRECTION, 8'he5);
      chk({5'h00, narrow_drive.oe_n}, 8'h05);
      tick(3);
      rd(dpio_pkg::ADDR_NARROW_PINS);
      chk(rd_val, 8'h07);
   endtask : t_narrow
   task automatic t_slave;
      @(posedge clk);
      board_narrow <= 3'h6;
      wr(dpio_pkg::ADDR_NARROW_DIRECTION, 8'hf7);
      chk({7'h00, slave_port_enable}, 8'h01);
      tick(3);
      chk({5'h00, slave_strobes}, 8'h06);
      @(posedge clk);
      slave_flags_set <= 3'h5;
      @(posedge clk);
      slave_flags_set <= 3'h0;
      rd(dpio_pkg::ADDR_NARROW_DIRECTION);
      chk(rd_val, 8'hb7);
      wr(dpio_pkg::ADDR_NARROW_DIRECTION, 8'h77);
      rd(dpio_pkg::ADDR_NARROW_DIRECTION);
      chk(rd_val, 8'h37);
      @(posedge clk);
      slave_flags_clear <= 1'b1;
      @(posedge clk);
      slave_flags_clear <= 1'b0;
      rd(dpio_pkg::ADDR_NARROW_DIRECTION);
      chk(rd_val, 8'h17);
      // set and clear in one cycle: the set must win
      @(posedge clk);
      slave_flags_set <= 3'h1;
      slave_flags_clear <= 1'b1;
      @(posedge clk);
      slave_flags_set <= 3'h0;
      slave_flags_clear <= 1'b0;
      rd(dpio_pkg::ADDR_NARROW_DIRECTION);
      chk(rd_val, 8'h37);
   endtask : t_slave
   // an unmapped place reads zero and swallows writes
   task automatic t_unmapped;
      wr(4'h8, 8'h3c);
      rd(4'h8);
      chk(rd_val, 8'h00);
      tick(1);
      chk(bus_rdata, 8'h00);
   endtask : t_unmapped

   // ----------------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      bus_req = '0;
      wide_override = '0;
      capture2_out = 1'b0;
      slave_flags_set = 3'h0;
      slave_flags_clear = 1'b0;
      board_wide = 8'h3c;
      board_narrow = 3'h5;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      t_reset();
      t_wide();
      t_override();
      t_narrow();
      t_slave();
      t_unmapped();
      tally_and_finish();
   end
endmodule : testbench
